// ==== src/dsg_pkg.sv ====
// Purpose: constants shared by the status gating block
// Assumes: binary one on a data line is marking, one on a control line is ON
// Notes: no register bus; all control and status travel as plain ports
`default_nettype none
package dsg_pkg;
   localparam logic MARK = 1'b1;
   localparam logic RESET_OFF = 1'b0;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   // modem-side handshake states
   typedef enum logic [1:0] {
      DSG_IDLE = 2'b00,
      DSG_WAIT = 2'b01,
      DSG_CLEAR = 2'b10,
      DSG_DRAIN = 2'b11
   } dsg_state_t;
   localparam int CTS_DELAY_CYCLES = 4;
   localparam logic [3:0] CTS_DELAY = 4'h4;
   localparam logic [3:0] COUNT_ZERO = 4'h0;
endpackage
`default_nettype wire

// ==== src/dsg_status_gating.sv ====
// Purpose: circuit-terminating side gating of the serial control and data circuits
// Assumes: line clock is the link clock port; ref_clk runs the control logic
// Notes: test-mode and loop handling beyond the ready clamp is left to the user logic
// Notes: the link domain has no reset of its own; the crossed gate parks it marking
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - ready shows only that the local unit is connected to its channel, never a remote link.
// - ready is OFF whenever the local connection is absent, and the terminal then ignores all but test mode.
// - during internal tests not run through the interface, ready is forced OFF.
// - during tests run through the interface, ready behaves normally.
// - the terminal drives tx data, its tx timing, request to send, terminal ready and both loop requests; this side drives the rest.
// - transmitted data is ignored unless request to send, clear to send, ready and terminal ready are all ON.
// - received data is held marking while line-signal detect is OFF.
module dsg_status_gating (
   // control clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link clock from the terminal
   input wire logic lineClk,
   // terminal-driven circuits
   input wire logic transmitted_data,
   input wire logic tx_timing_from_terminal,
   input wire logic request_to_send,
   input wire logic terminal_ready,
   input wire logic local_loop_request,
   input wire logic remote_loop_request,
   // local unit status
   input wire logic channelConnected,
   input wire logic internalTest,
   input wire logic interfaceTest,
   input wire logic carrierPresent,
   input wire logic lineRxData,
   // circuits toward the terminal
   output logic received_data,
   output logic clear_to_send,
   output logic line_signal_detect,
   output logic modem_ready,
   output logic test_mode_indication,
   output logic localLoopActive,
   output logic remoteLoopActive,
   // channel side
   output logic channelTxData,
   output logic channelTxValid
);
   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers on ref_clk for eight input pins, interfaceTest is used unsynchronised; nothing comes back from the link domain
   // pin levels and loop requests arrive with no relation to ref_clk
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] syncIn;
   logic [NSYNC-1:0] syncOut;
   assign syncIn = {request_to_send, terminal_ready, local_loop_request,
                    remote_loop_request, channelConnected, internalTest,
                    carrierPresent, lineRxData};
   // every bit gets its own flop pair so no logic ever reads a first stage
   for (genvar i = 0; i < NSYNC; i++) begin : gSyncBit
      logic syncA_reg, syncA_next;
      logic syncB_reg, syncB_next;
      always_comb begin
         syncA_next = syncIn[i];
         syncB_next = syncA_reg;
         if (!resetn) begin
            syncA_next = dsg_pkg::RESET_OFF;
            syncB_next = dsg_pkg::RESET_OFF;
         end
      end
      always_ff @(posedge ref_clk) begin
         syncA_reg <= syncA_next;
         syncB_reg <= syncB_next;
      end
      assign syncOut[i] = syncB_reg;
   end
   // synchronised copies, named after the circuit they carry
   logic rtsS, dtrS, llS, rlS, connS, itestS, carrS, rxS;
   assign rtsS = syncOut[7];
   assign dtrS = syncOut[6];
   assign llS = syncOut[5];
   assign rlS = syncOut[4];
   assign connS = syncOut[3];
   assign itestS = syncOut[2];
   assign carrS = syncOut[1];
   assign rxS = syncOut[0];

   ////////////////////////////////////////////////////////////////////////////
   // ready indication
   logic ready_reg, ready_next;
   always_comb begin
      // ready tracks the local connection and is clamped OFF by internal tests; interface tests do not clamp it
      ready_next = connS & ~itestS;
      if (!resetn) begin
         ready_next = dsg_pkg::RESET_OFF;
      end
   end
   always_ff @(posedge ref_clk) begin
      ready_reg <= ready_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // line-signal detect and received data
   logic cd_reg, cd_next;
   logic rx_reg, rx_next;
   always_comb begin
      cd_next = carrS;
      // a lost carrier clamps received data so line noise never reaches the terminal
      rx_next = carrS ? rxS : dsg_pkg::MARK;
      if (!resetn) begin
         cd_next = dsg_pkg::RESET_OFF;
         rx_next = dsg_pkg::MARK;
      end
   end
   always_ff @(posedge ref_clk) begin
      cd_reg <= cd_next;
      rx_reg <= rx_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // test mode indication
   logic tm_reg, tm_next;
   always_comb begin
      // test mode stays meaningful while ready is OFF
      // interface tests raise test mode without touching ready
      tm_next = itestS | interfaceTest | llS | rlS;
      if (!resetn) begin
         tm_next = dsg_pkg::RESET_OFF;
      end
   end
   always_ff @(posedge ref_clk) begin
      tm_reg <= tm_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // loop request echoes
   logic ll_reg, ll_next;
   logic rl_reg, rl_next;
   always_comb begin
      // loops are only echoed while the unit is on its channel
      ll_next = llS & ready_reg;
      rl_next = rlS & ready_reg;
      if (!resetn) begin
         ll_next = dsg_pkg::RESET_OFF;
         rl_next = dsg_pkg::RESET_OFF;
      end
   end
   always_ff @(posedge ref_clk) begin
      ll_reg <= ll_next;
      rl_reg <= rl_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // clear-to-send handshake
   // countdown helpers shared by waiting and draining
   // true once a handshake countdown has run out
   function automatic logic countDone(input logic [3:0] cnt);
      countDone = (cnt == dsg_pkg::COUNT_ZERO);
   endfunction

   // next countdown value; it parks at zero rather than wrapping
   function automatic logic [3:0] countStep(input logic [3:0] cnt);
      countStep = countDone(cnt) ? dsg_pkg::COUNT_ZERO : cnt - 4'h1;
   endfunction

   dsg_pkg::dsg_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         dsg_pkg::DSG_IDLE: begin
            if (rtsS && ready_reg) begin
               state_next = dsg_pkg::DSG_WAIT;
               cnt_next = dsg_pkg::CTS_DELAY;
            end
         end
         dsg_pkg::DSG_WAIT: begin
            if (!rtsS || !ready_reg) begin
               state_next = dsg_pkg::DSG_IDLE;
            end else if (countDone(cnt_reg)) begin
               state_next = dsg_pkg::DSG_CLEAR;
            end else begin
               cnt_next = countStep(cnt_reg);
            end
         end
         dsg_pkg::DSG_CLEAR: begin
            // a drop of request to send lowers clear to send at once, then drains
            if (!rtsS || !ready_reg) begin
               state_next = dsg_pkg::DSG_DRAIN;
               cnt_next = dsg_pkg::CTS_DELAY;
            end
         end
         dsg_pkg::DSG_DRAIN: begin
            // terminal waits for clear to send OFF before raising request again
            if (countDone(cnt_reg)) begin
               state_next = dsg_pkg::DSG_IDLE;
            end else begin
               cnt_next = countStep(cnt_reg);
            end
         end
         default: begin
            // an upset state code falls back to idle rather than locking up
            state_next = dsg_pkg::DSG_IDLE;
         end
      endcase
      if (!resetn) begin
         state_next = dsg_pkg::DSG_IDLE;
         cnt_next = dsg_pkg::COUNT_ZERO;
      end
   end
   always_ff @(posedge ref_clk) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // clear to send follows the next state, so it drops on the edge that enters draining
   logic cts_reg, cts_next;
   always_comb begin
      cts_next = (state_next == dsg_pkg::DSG_CLEAR);
      if (!resetn) begin
         cts_next = dsg_pkg::RESET_OFF;
      end
   end
   always_ff @(posedge ref_clk) begin
      cts_reg <= cts_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // gate level toward the link domain
   // all four circuits must be ON before a single bit is forwarded
   function automatic logic linkOpen(input logic rts, input logic cts, input logic rdy,
                                     input logic dtr);
      linkOpen = rts & cts & rdy & dtr;
   endfunction

   logic gate_reg, gate_next;
   always_comb begin
      gate_next = linkOpen(rtsS, cts_reg, ready_reg, dtrS);
      if (!resetn) begin
         gate_next = dsg_pkg::RESET_OFF;
      end
   end
   always_ff @(posedge ref_clk) begin
      gate_reg <= gate_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: samples tx data on the terminal's timing edge
   // the link reset is the ref-domain gate itself, so no reset crosses separately;
   // a stopped line clock leaves the last values, which the gate cannot mask until the clock runs again
   logic [1:0] gSync_reg, gSync_next;
   logic [1:0] dSync_reg, dSync_next;
   logic [1:0] tSync_reg, tSync_next;
   always_comb begin
      gSync_next = {gSync_reg[0], gate_reg};
      dSync_next = {dSync_reg[0], transmitted_data};
      tSync_next = {tSync_reg[0], tx_timing_from_terminal};
   end
   always_ff @(posedge lineClk) begin
      gSync_reg <= gSync_next;
      dSync_reg <= dSync_next;
      tSync_reg <= tSync_next;
   end

   // rising edge of the synchronised timing marks the centre of a bit
   logic tPrev_reg, tPrev_next;
   always_comb begin
      tPrev_next = tSync_reg[1];
   end
   always_ff @(posedge lineClk) begin
      tPrev_reg <= tPrev_next;
   end

   // forwarded bit and its one-cycle strobe
   logic txd_reg, txd_next;
   logic txv_reg, txv_next;
   always_comb begin
      txv_next = gSync_reg[1] & tSync_reg[1] & ~tPrev_reg;
      // ignored data leaves the channel marking
      txd_next = gSync_reg[1] ? (txv_next ? dSync_reg[1] : txd_reg) : dsg_pkg::MARK;
   end
   always_ff @(posedge lineClk) begin
      txd_reg <= txd_next;
      txv_reg <= txv_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // every output below is a flop; nothing combinational reaches a pin
   // control circuits toward the terminal
   assign received_data = rx_reg;
   assign clear_to_send = cts_reg;
   assign line_signal_detect = cd_reg;
   assign modem_ready = ready_reg;
   assign test_mode_indication = tm_reg;
   // loop echoes
   assign localLoopActive = ll_reg;
   assign remoteLoopActive = rl_reg;
   // channel side, link clock domain
   assign channelTxData = txd_reg;
   assign channelTxValid = txv_reg;
endmodule
`default_nettype wire

// ==== tb/dsg_status_gating_props.sv ====
// Purpose: concurrent checks on the status gating ports
// Assumes: control outputs settle within five ref_clk edges of their inputs
// Notes: bound to every instance of the gating block
`default_nettype none
module dsg_status_gating_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic request_to_send,
   input wire logic terminal_ready,
   input wire logic channelConnected,
   input wire logic internalTest,
   input wire logic carrierPresent,
   input wire logic received_data,
   input wire logic clear_to_send,
   input wire logic modem_ready,
   input wire logic test_mode_indication,
   input wire logic channelTxData,
   input wire logic channelTxValid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence connHeld;
      (channelConnected && !internalTest)[*5];
   endsequence
   sequence testHeld;
      internalTest[*5];
   endsequence
   chk_ready_follows: assert property (connHeld |-> modem_ready)
      else $error("ready missing while connected");
   chk_ready_absent: assert property ((!channelConnected)[*5] |-> !modem_ready)
      else $error("ready on without connection");
   chk_ready_clamp: assert property (testHeld |-> !modem_ready)
      else $error("ready on during internal test");
   chk_test_flag: assert property (testHeld |-> test_mode_indication)
      else $error("test mode not shown");
   chk_rx_marking: assert property ((!carrierPresent)[*5] |-> received_data)
      else $error("received data not marking");
   chk_cts_release: assert property ((!request_to_send)[*8] |-> !clear_to_send)
      else $error("clear to send held without request");
   chk_cts_delay: assert property ($rose(clear_to_send) |-> $past(request_to_send, 5))
      else $error("clear to send too early");
   chk_tx_gated: assert property ((!terminal_ready)[*6] |-> channelTxData && !channelTxValid)
      else $error("data forwarded while gated");
endmodule
bind dsg_status_gating dsg_status_gating_props chkProps (.ref_clk, .resetn, .request_to_send,
   .terminal_ready, .channelConnected, .internalTest, .carrierPresent, .received_data,
   .clear_to_send, .modem_ready, .test_mode_indication, .channelTxData, .channelTxValid);
`default_nettype wire

// ==== tb/dsg_terminal_model.sv ====
// Purpose: behavioural terminal driving the interchange circuits
// Assumes: breakMark is the only commanded misbehaviour
// Notes: timing only toggles while sending, it stands still otherwise
`default_nettype none
module dsg_terminal_model (
   input wire logic ref_clk,
   input wire logic lineClk,
   input wire logic wantSend,
   input wire logic dtrWanted,
   input wire logic dataBit,
   input wire logic breakMark,
   input wire logic clear_to_send,
   input wire logic modem_ready,
   output logic transmitted_data,
   output logic tx_timing_from_terminal,
   output logic request_to_send,
   output logic terminal_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] divReg = 3'h0;
   logic waitReg = 1'b0;
   initial request_to_send = 1'b0;
   initial terminal_ready = 1'b0;
   always @(posedge ref_clk) begin
      terminal_ready <= dtrWanted;
      if (!wantSend && request_to_send) waitReg <= 1'b1;
      else if (!clear_to_send) waitReg <= 1'b0;
      request_to_send <= wantSend && !waitReg;
   end
   always @(posedge lineClk) if (wantSend) divReg <= divReg + 3'h1;
   assign tx_timing_from_terminal = divReg[2];
   // marking unless every handshake is on or breakMark is set
   assign transmitted_data = (breakMark || (request_to_send && clear_to_send && modem_ready
      && terminal_ready)) ? dataBit : 1'b1;
endmodule
`default_nettype wire

// ==== tb/tb_dsg_status_gating.sv ====
// Purpose: random and corner stimulus for the status gating block
// Assumes: outputs settle within six ref_clk cycles
// Notes: fixed seed keeps runs repeatable
`default_nettype none
module tb_dsg_status_gating;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, lineClk = 0, resetn = 0, conn = 0, iTest = 0, ifTest = 0, carrier = 0;
   logic rxData = 0, llReq = 0, rlReq = 0, wantSend = 0, dtrWanted = 0, dataBit = 1, brk = 0;
   logic txd, txTim, rts, dtr, rxd, cts, lsd, ready, tmi, llAct, rlAct, chData, chValid;
   int failCount = 0, samplesChecked = 0, seed = 37, vCount = 0, vStart = 0, k;
   logic [31:0] r;
   always #10 ref_clk = ~ref_clk;
   initial #1.3 forever #3 lineClk = ~lineClk;
   always @(posedge lineClk) dataBit <= $random(seed);
   always @(posedge lineClk) if (chValid === 1'b1) vCount <= vCount + 1;
   dsg_status_gating uut (.ref_clk, .resetn, .lineClk, .transmitted_data(txd),
      .tx_timing_from_terminal(txTim), .request_to_send(rts), .terminal_ready(dtr),
      .local_loop_request(llReq), .remote_loop_request(rlReq), .channelConnected(conn),
      .internalTest(iTest), .interfaceTest(ifTest), .carrierPresent(carrier), .lineRxData(rxData),
      .received_data(rxd), .clear_to_send(cts), .line_signal_detect(lsd), .modem_ready(ready),
      .test_mode_indication(tmi), .localLoopActive(llAct), .remoteLoopActive(rlAct),
      .channelTxData(chData), .channelTxValid(chValid));
   dsg_terminal_model term (.ref_clk, .lineClk, .wantSend, .dtrWanted, .dataBit, .breakMark(brk),
      .clear_to_send(cts), .modem_ready(ready), .transmitted_data(txd),
      .tx_timing_from_terminal(txTim), .request_to_send(rts), .terminal_ready(dtr));
   task chk(input string name, input logic exp, input logic got);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask
   task reportAndStop;
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // bounded wait, a stall ends the run
   task waitCts(input logic lvl);
      k = 0;
      while (cts !== lvl && k < 60) begin
         tick(1);
         k++;
      end
      chk("ctsWait", lvl, cts);
      if (cts !== lvl) reportAndStop();
   endtask
   initial begin
      tick(16);
      resetn = 1;
      repeat (40) begin
         r = $random(seed);
         {conn, iTest, ifTest, carrier, rxData, llReq, rlReq} = r[6:0];
         tick(6);
         chk("ready", conn & ~iTest, ready);
         chk("rxd", carrier ? rxData : 1'b1, rxd);
         chk("lsd", carrier, lsd);
         chk("llAct", conn & ~iTest & llReq, llAct);
         chk("rlAct", conn & ~iTest & rlReq, rlAct);
         chk("tmi", iTest | ifTest | llReq | rlReq, tmi);
      end
      {conn, iTest, ifTest, llReq, rlReq, dtrWanted, wantSend} = 7'h43;
      waitCts(1);
      vStart = vCount;
      tick(40);
      chk("txValid", 1'b1, vCount > vStart);
      wantSend = 0;
      tick(1);
      wantSend = 1;
      waitCts(0);
      waitCts(1);
      dtrWanted = 0;
      brk = 1;
      tick(8);
      vStart = vCount;
      tick(40);
      chk("txGated", 1'b1, vCount == vStart);
      chk("txMark", 1'b1, chData);
      conn = 0;
      tick(12);
      chk("ctsDrop", 1'b0, cts);
      reportAndStop();
   end
endmodule
`default_nettype wire
